// ==== verilog/arcc_pkg.sv ====
// arcc_pkg: constants, register map, modes and carrier types for the
// automatic rearm and compare controller.
// assumes a 100 MHz hclk and a 32-bit AHB-Lite register bus.
//
// Overview of operation
// - auto modes rearm and record again after each completed recording
// - report trace level, recording index in progress, and completed count
// - stalled trace condition halts recording, reports level, freezes count
// - when the stalled condition clears, recording resumes where it stopped
// - lost external sample clock halts recording with a missing-clock status
// - operator halt or cycle end sets the trace status to ready
// - count held after a cycle; a new arm clears it and restarts
// - nonzero limit stops auto recording when completed count reaches it
// - stop-on-inequality compares each recording against reference memory
// - any differing sample ends auto arming, both memories kept
// - copy command moves acquisition memory into reference memory
// - mode 5 stops on mismatch within the limited sample range only
// - every channel of every group has its own polarity applied
// - internal clock samples asynchronously, placement may vary by one
// - register access interrupts the acquisition loop only through the ctrl halt bit
// - manual mode makes one recording per arm command, then waits
// - mode codes: 0 manual, 1 auto, 2 eq, 3 neq, 4 eq within limits
// - pass-counter limit ranges from zero to 9999
package arcc_pkg;

	localparam int DEPTH    = 512;
	localparam int AW       = 9;
	localparam int CHANS    = 16;
	localparam int GROUPS   = 3;
	localparam int SW       = CHANS * GROUPS;

	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_LIMIT   = 8'h04;
	localparam logic [7:0] OFS_WINDOW  = 8'h08;
	localparam logic [7:0] OFS_PERIOD  = 8'h0C;
	localparam logic [7:0] OFS_POL_A   = 8'h10;
	localparam logic [7:0] OFS_POL_B   = 8'h14;
	localparam logic [7:0] OFS_POL_C   = 8'h18;
	localparam logic [7:0] OFS_STATUS  = 8'h1C;
	localparam logic [7:0] OFS_COUNT   = 8'h20;
	localparam logic [7:0] OFS_INT_ST  = 8'h24;
	localparam logic [7:0] OFS_INT_MSK = 8'h28;
	localparam logic [7:0] OFS_MEM_ADR = 8'h2C;
	localparam logic [7:0] OFS_ACQ_LO  = 8'h30;
	localparam logic [7:0] OFS_ACQ_HI  = 8'h34;
	localparam logic [7:0] OFS_REF_LO  = 8'h38;
	localparam logic [7:0] OFS_REF_HI  = 8'h3C;

	// ctrl and window field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_EXT_BIT  = 3;
	localparam int CTRL_ARM_BIT  = 8;
	localparam int CTRL_HALT_BIT = 9;
	localparam int CTRL_COPY_BIT = 10;
	localparam int WIN_HI_LSB    = 16;

	localparam logic [13:0] LIMIT_MAX   = 14'h270F;
	localparam logic [15:0] PERIOD_RST  = 16'h0003;
	localparam logic [AW-1:0] WIN_LO_RST = 9'h000;
	localparam logic [AW-1:0] WIN_HI_RST = 9'h1FF;

	// interrupt bits
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_END   = 1;
	localparam int IRQ_STALL = 2;
	localparam int IRQ_NOCLK = 3;
	localparam int IRQ_W     = 4;

	// external clock loss detection
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_LOSS_NS   = 2000;
	localparam int CLK_LOSS_CYC  =
		(CLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		MODE_MANUAL  = 3'h0,
		MODE_AUTO    = 3'h1,
		MODE_EQ      = 3'h2,
		MODE_NEQ     = 3'h3,
		MODE_EQ_WIN  = 3'h4,
		MODE_NEQ_WIN = 3'h5
	} arcc_mode_e;

	typedef enum logic [1:0] {
		TS_READY = 2'h0,
		TS_RUN   = 2'h1,
		TS_STUCK = 2'h2,
		TS_NOCLK = 2'h3
	} arcc_tstat_e;

	typedef struct packed {
		logic [2:0]  mode;
		logic        ext_sel;
		logic [13:0] limit;
		logic [AW-1:0] win_lo;
		logic [AW-1:0] win_hi;
		logic [15:0] period;
	} arcc_cfg_s;

	typedef struct packed {
		logic        stalled;
		logic        clk_missing;
		logic        mism_all;
		logic        mism_win;
	} arcc_flags_s;

endpackage

// ==== verilog/arcc_top.sv ====
// arcc_top: arm/rearm controller with acquisition and reference memories,
// recording compare, pass counter and AHB-Lite register slave.
// assumes probe data and external sample clock come asynchronously from
// the target; trace level and hold come from the sequencer on hclk.
`timescale 1ns/1ns
module arcc_top
	import arcc_pkg::*;
(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	output logic               irq,
	input  wire logic [SW-1:0] probe_data,
	input  wire logic          ext_clk,
	input  wire logic [3:0]    trace_level,
	input  wire logic          trace_hold,
	output logic               trace_ready
);

	typedef enum {ST_IDLE, ST_REC, ST_EVAL, ST_COPY} arcc_state_e;

	arcc_state_e       state_reg;
	arcc_cfg_s         cfg_reg;
	arcc_flags_s       flg_reg;
	logic [SW-1:0]     pol_reg;
	logic [15:0]       count_reg;
	logic [AW-1:0]     wr_addr_reg;
	logic [AW-1:0]     mem_addr_reg;
	logic [IRQ_W-1:0]  int_st_reg;
	logic [IRQ_W-1:0]  int_msk_reg;
	logic [IRQ_W-1:0]  int_set;
	logic [SW-1:0]     acq_mem [DEPTH];
	logic [SW-1:0]     ref_mem [DEPTH];

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and sample strobe

	logic [SW-1:0]     data_s1_reg;
	logic [SW-1:0]     data_s2_reg;
	logic [2:0]        eclk_reg;
	logic [15:0]       div_reg;
	logic [7:0]        loss_reg;
	logic              ext_edge;
	logic              int_tick;
	logic              sample_en;
	logic [SW-1:0]     sample_val;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			data_s1_reg <= '0;
			data_s2_reg <= '0;
			eclk_reg    <= 3'h0;
		end
		else
		begin
			data_s1_reg <= probe_data;
			data_s2_reg <= data_s1_reg;
			eclk_reg    <= {eclk_reg[1:0], ext_clk};
		end
	end

	assign ext_edge = eclk_reg[1] & ~eclk_reg[2];

	// internal period runs free of the target, so the phase is arbitrary
	// and identical recordings can shift by one sample
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			div_reg <= 16'h0000;
		else if (div_reg >= cfg_reg.period)
			div_reg <= 16'h0000;
		else
			div_reg <= div_reg + 16'h0001;
	end

	assign int_tick  = (div_reg >= cfg_reg.period);
	assign sample_en = cfg_reg.ext_sel ? ext_edge : int_tick;
	assign sample_val = data_s2_reg ^ pol_reg;

	// cycles since the last external edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			loss_reg <= 8'h00;
		else if (ext_edge || !cfg_reg.ext_sel)
			loss_reg <= 8'h00;
		else if (loss_reg < 8'(CLK_LOSS_CYC))
			loss_reg <= loss_reg + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave

	logic              ph_wr_reg;
	logic [7:0]        ph_addr_reg;
	logic              addr_ok;
	logic              wr_go;
	logic [7:0]        a_ofs;
	logic              arm_cmd;
	logic              halt_cmd;
	logic              copy_cmd;
	logic              rd_int;
	logic [31:0]       rd_val;
	logic [1:0]        tstat;
	logic [15:0]       rec_index;
	logic [SW-1:0]     acq_word;
	logic [SW-1:0]     ref_word;

	assign addr_ok = hsel & htrans[1] & hready;
	assign a_ofs   = {haddr[7:2], 2'b00};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_wr_reg   <= 1'b0;
			ph_addr_reg <= 8'h00;
		end
		else if (hready)
		begin
			ph_wr_reg   <= addr_ok & hwrite;
			ph_addr_reg <= a_ofs;
		end
	end

	assign wr_go    = ph_wr_reg;
	assign arm_cmd  = wr_go && ph_addr_reg == OFS_CTRL &&
		hwdata[CTRL_ARM_BIT];
	assign halt_cmd = wr_go && ph_addr_reg == OFS_CTRL &&
		hwdata[CTRL_HALT_BIT];
	assign copy_cmd = wr_go && ph_addr_reg == OFS_CTRL &&
		hwdata[CTRL_COPY_BIT];
	assign rd_int   = addr_ok && !hwrite && a_ofs == OFS_INT_ST;

	// configuration writes take effect without disturbing the loop
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg_reg.mode    <= MODE_MANUAL;
			cfg_reg.ext_sel <= 1'b0;
			cfg_reg.limit   <= 14'h0000;
			cfg_reg.win_lo  <= WIN_LO_RST;
			cfg_reg.win_hi  <= WIN_HI_RST;
			cfg_reg.period  <= PERIOD_RST;
			pol_reg         <= '0;
			int_msk_reg     <= '0;
			mem_addr_reg    <= '0;
		end
		else if (wr_go)
		begin
			case (ph_addr_reg)
				OFS_CTRL:
				begin
					cfg_reg.mode    <= hwdata[CTRL_MODE_LSB +: 3];
					cfg_reg.ext_sel <= hwdata[CTRL_EXT_BIT];
				end
				OFS_LIMIT:
					cfg_reg.limit <= (hwdata[13:0] > LIMIT_MAX) ?
						LIMIT_MAX : hwdata[13:0];
				OFS_WINDOW:
				begin
					cfg_reg.win_lo <= hwdata[AW-1:0];
					cfg_reg.win_hi <= hwdata[WIN_HI_LSB +: AW];
				end
				OFS_PERIOD:  cfg_reg.period <= hwdata[15:0];
				OFS_POL_A:   pol_reg[15:0]  <= hwdata[15:0];
				OFS_POL_B:   pol_reg[31:16] <= hwdata[15:0];
				OFS_POL_C:   pol_reg[47:32] <= hwdata[15:0];
				OFS_INT_MSK: int_msk_reg    <= hwdata[IRQ_W-1:0];
				OFS_MEM_ADR: mem_addr_reg   <= hwdata[AW-1:0];
				default:     ;
			endcase
		end
	end

	assign acq_word  = acq_mem[mem_addr_reg];
	assign ref_word  = ref_mem[mem_addr_reg];
	assign rec_index = (state_reg == ST_IDLE) ? 16'h0000 :
		count_reg + 16'h0001;

	always_comb
	begin
		if (state_reg == ST_IDLE || state_reg == ST_COPY)
			tstat = TS_READY;
		else if (flg_reg.clk_missing)
			tstat = TS_NOCLK;
		else if (flg_reg.stalled)
			tstat = TS_STUCK;
		else
			tstat = TS_RUN;
	end

	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (a_ofs)
			OFS_CTRL:    rd_val = {28'h0, cfg_reg.ext_sel, cfg_reg.mode};
			OFS_LIMIT:   rd_val = {18'h0, cfg_reg.limit};
			OFS_WINDOW:  rd_val = {7'h0, cfg_reg.win_hi, 7'h0,
				cfg_reg.win_lo};
			OFS_PERIOD:  rd_val = {16'h0, cfg_reg.period};
			OFS_POL_A:   rd_val = {16'h0, pol_reg[15:0]};
			OFS_POL_B:   rd_val = {16'h0, pol_reg[31:16]};
			OFS_POL_C:   rd_val = {16'h0, pol_reg[47:32]};
			// level and index in progress beside status word
			OFS_STATUS:  rd_val = {rec_index, 4'h0, trace_level, 2'h0,
				flg_reg.mism_win, flg_reg.mism_all,
				flg_reg.clk_missing, flg_reg.stalled, tstat};
			OFS_COUNT:   rd_val = {16'h0, count_reg};
			OFS_INT_ST:  rd_val = {28'h0, int_st_reg};
			OFS_INT_MSK: rd_val = {28'h0, int_msk_reg};
			OFS_MEM_ADR: rd_val = {23'h0, mem_addr_reg};
			OFS_ACQ_LO:  rd_val = acq_word[31:0];
			OFS_ACQ_HI:  rd_val = {16'h0, acq_word[47:32]};
			OFS_REF_LO:  rd_val = ref_word[31:0];
			OFS_REF_HI:  rd_val = {16'h0, ref_word[47:32]};
			default:     rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_ok && !hwrite)
				hrdata <= rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// arm sequencer

	logic              can_step;
	logic              in_win;
	logic              differs;
	logic [15:0]       cnt_next;
	logic              lim_hit;
	logic              cmp_stop;

	assign can_step = sample_en && !trace_hold && !flg_reg.clk_missing;
	assign differs  = sample_val != ref_mem[wr_addr_reg];
	assign in_win   = wr_addr_reg >= cfg_reg.win_lo &&
		wr_addr_reg <= cfg_reg.win_hi;
	assign cnt_next = count_reg + 16'h0001;
	// zero limit never stops the loop
	assign lim_hit  = cfg_reg.limit != 14'h0000 &&
		cnt_next >= {2'b00, cfg_reg.limit};

	always_comb
	begin
		case (cfg_reg.mode)
			MODE_MANUAL:  cmp_stop = 1'b1;
			MODE_AUTO:    cmp_stop = 1'b0;
			MODE_EQ:      cmp_stop = !flg_reg.mism_all;
			MODE_NEQ:     cmp_stop = flg_reg.mism_all;
			MODE_EQ_WIN:  cmp_stop = !flg_reg.mism_win;
			MODE_NEQ_WIN: cmp_stop = flg_reg.mism_win;
			default:      cmp_stop = 1'b1;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg   <= ST_IDLE;
			wr_addr_reg <= '0;
			count_reg   <= 16'h0000;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					wr_addr_reg <= '0;
					if (arm_cmd)
					begin
						count_reg <= 16'h0000;
						state_reg <= ST_REC;
					end
					else if (copy_cmd)
						state_reg <= ST_COPY;
				end
				ST_REC:
				begin
					if (halt_cmd)
						state_reg <= ST_IDLE;
					else if (can_step)
					begin
						wr_addr_reg <= wr_addr_reg + 1'b1;
						if (wr_addr_reg == AW'(DEPTH - 1))
							state_reg <= ST_EVAL;
					end
				end
				ST_EVAL:
				begin
					count_reg   <= cnt_next;
					wr_addr_reg <= '0;
					if (halt_cmd || lim_hit || cmp_stop)
						state_reg <= ST_IDLE;
					else
						state_reg <= ST_REC;
				end
				ST_COPY:
				begin
					wr_addr_reg <= wr_addr_reg + 1'b1;
					if (wr_addr_reg == AW'(DEPTH - 1))
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// memories: recording writes acquisition, copy fills the reference
	always_ff @(posedge hclk)
	begin
		if (state_reg == ST_REC && can_step)
			acq_mem[wr_addr_reg] <= sample_val;
		if (state_reg == ST_COPY)
			ref_mem[wr_addr_reg] <= acq_mem[wr_addr_reg];
	end

	// compare flags and stall indications
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flg_reg <= '0;
		else
		begin
			flg_reg.stalled     <= state_reg == ST_REC && trace_hold;
			flg_reg.clk_missing <= cfg_reg.ext_sel &&
				state_reg == ST_REC && loss_reg >= 8'(CLK_LOSS_CYC);
			if (arm_cmd || state_reg == ST_EVAL)
			begin
				flg_reg.mism_all <= 1'b0;
				flg_reg.mism_win <= 1'b0;
			end
			else if (state_reg == ST_REC && can_step && differs)
			begin
				flg_reg.mism_all <= 1'b1;
				if (in_win)
					flg_reg.mism_win <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: sticky, cleared by read, set wins over the clear

	logic              stall_d_reg;
	logic              noclk_d_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stall_d_reg <= 1'b0;
			noclk_d_reg <= 1'b0;
		end
		else
		begin
			stall_d_reg <= flg_reg.stalled;
			noclk_d_reg <= flg_reg.clk_missing;
		end
	end

	always_comb
	begin
		int_set            = '0;
		int_set[IRQ_DONE]  = state_reg == ST_EVAL;
		int_set[IRQ_END]   = state_reg == ST_EVAL &&
			(halt_cmd || lim_hit || cmp_stop);
		int_set[IRQ_STALL] = flg_reg.stalled && !stall_d_reg;
		int_set[IRQ_NOCLK] = flg_reg.clk_missing && !noclk_d_reg;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			int_st_reg  <= '0;
			irq         <= 1'b0;
			trace_ready <= 1'b1;
		end
		else
		begin
			int_st_reg  <= (rd_int ? '0 : int_st_reg) | int_set;
			irq         <= |(((rd_int ? '0 : int_st_reg) | int_set) &
				int_msk_reg);
			trace_ready <= tstat == TS_READY;
		end
	end

endmodule // arcc_top

// ==== test/arcc_monitor.sv ====
// arcc_monitor: bus and control checks on the arcc_top ports.
// assumes it is bound into every arcc_top instance.
`timescale 1ns/1ns
module arcc_monitor
	import arcc_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        irq,
	input wire logic [3:0]  trace_level,
	input wire logic        trace_hold,
	input wire logic        trace_ready
);
	logic       wr_ph;
	logic [7:0] ofs_ph;
	logic [3:0] msk;
	logic [2:0] quiet;
	logic       rd_ad;
	logic       ctl_ph;
	assign rd_ad = hsel && htrans[1] && hready && !hwrite;
	assign ctl_ph = wr_ph && ofs_ph == OFS_CTRL;
	// write data phase tracking
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_ph <= 1'b0;
			ofs_ph <= 8'h00;
		end
		else
		begin
			wr_ph <= hsel && htrans[1] && hready && hwrite;
			ofs_ph <= haddr[7:0];
		end
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			msk <= 4'h0;
		else if (wr_ph && ofs_ph == OFS_INT_MSK)
			msk <= hwdata[3:0];
	end
	// cycles since the last register write, so halts are kept apart
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			quiet <= 3'h0;
		else if (wr_ph)
			quiet <= 3'h0;
		else if (quiet != 3'h7)
			quiet <= quiet + 3'h1;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_rdy;
		hreadyout && !hresp;
	endproperty
	a_rdy: assert property (p_rdy)
		else $error("bus stalled or errored");
	property p_hold;
		!rd_ad |=> $stable(hrdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");
	property p_lim;
		rd_ad && haddr[7:0] == OFS_LIMIT |=> hrdata <= 32'h0000270F;
	endproperty
	a_lim: assert property (p_lim)
		else $error("limit above range");
	property p_lvl;
		rd_ad && haddr[7:0] == OFS_STATUS && $stable(trace_level)
			|=> hrdata[11:8] == $past(trace_level);
	endproperty
	a_lvl: assert property (p_lvl)
		else $error("status level wrong");
	property p_arm;
		ctl_ph && hwdata[CTRL_ARM_BIT] && !hwdata[CTRL_HALT_BIT]
			&& !hwdata[CTRL_COPY_BIT] |-> ##[1:3] !trace_ready;
	endproperty
	a_arm: assert property (p_arm)
		else $error("arm did not start");
	property p_halt;
		ctl_ph && hwdata[CTRL_HALT_BIT] && !hwdata[CTRL_ARM_BIT]
			&& !trace_ready |-> ##[1:3] trace_ready;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt did not reach ready");
	property p_copy;
		ctl_ph && hwdata[CTRL_COPY_BIT] && !hwdata[CTRL_ARM_BIT]
			&& trace_ready |=> trace_ready[*8];
	endproperty
	a_copy: assert property (p_copy)
		else $error("copy left ready");
	property p_stall;
		(trace_hold && !trace_ready && quiet == 3'h7)[*5] |=> !trace_ready;
	endproperty
	a_stall: assert property (p_stall)
		else $error("stalled recording ended");
	property p_irq;
		msk == 4'h0 && $past(msk) == 4'h0 |-> !irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("masked interrupt raised");
endmodule // arcc_monitor
bind arcc_top arcc_monitor u_arcc_monitor (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq,
	.trace_level, .trace_hold, .trace_ready);

// ==== test/arcc_target.sv ====
// arcc_target: stand-in for the probed target system.
// assumes the bench sets the probe pattern and starts the sample clock.
`timescale 1ns/1ns
module arcc_target
	import arcc_pkg::*;
(
	input  wire logic [SW-1:0] pattern,
	input  wire logic          clk_on,
	output logic               ext_clk,
	output logic [SW-1:0]      probe_data
);
	// 125 ns sample clock, held low while stopped
	always
	begin
		ext_clk = 1'b0;
		#62;
		ext_clk = clk_on;
		#63;
	end
	assign probe_data = pattern;
endmodule // arcc_target

// ==== test/tb_top.sv ====
// tb_top: self-checking bench for arcc_top with the target model.
// assumes zero wait state AHB-Lite answers and a 100 MHz hclk.
`timescale 1ns/1ns
module tb_top
	import arcc_pkg::*;
;
	typedef struct packed {
		logic [7:0]  a;
		logic        w;
		logic [31:0] d;
		logic [31:0] e;
	} arcc_row_s;
	localparam logic [SW-1:0] P0 = 48'hABCD123400F0;
	localparam logic [SW-1:0] P1 = 48'h5555AAAA0F0F;
	localparam arcc_row_s ROWS [13] = '{
		'{OFS_CTRL, 1'b0, 32'h0, 32'h0},
		'{OFS_LIMIT, 1'b0, 32'h0, 32'h0},
		'{OFS_WINDOW, 1'b0, 32'h0, 32'h01FF0000},
		'{OFS_PERIOD, 1'b0, 32'h0, 32'h3},
		'{OFS_STATUS, 1'b0, 32'h0, 32'h0},
		'{OFS_COUNT, 1'b0, 32'h0, 32'h0},
		'{OFS_INT_ST, 1'b0, 32'h0, 32'h0},
		'{8'h40, 1'b1, 32'hFFFFFFFF, 32'h0},
		'{OFS_LIMIT, 1'b1, 32'h3FFF, 32'h270F},
		'{OFS_CTRL, 1'b1, 32'h5, 32'h5},
		'{OFS_POL_A, 1'b1, 32'hFFFF, 32'hFFFF},
		'{OFS_PERIOD, 1'b1, 32'h0, 32'h0},
		'{OFS_LIMIT, 1'b1, 32'h0, 32'h0}};
	logic          hclk = 1'b0;
	logic          hresetn = 1'b0;
	logic          hsel = 1'b0;
	logic [31:0]   haddr = 32'h0;
	logic [1:0]    htrans = 2'h0;
	logic          hwrite = 1'b0;
	logic [2:0]    hsize = 3'h2;
	logic [31:0]   hwdata = 32'h0;
	logic          hready;
	logic          hresp;
	logic [31:0]   hrdata;
	logic          irq;
	logic [SW-1:0] probe_data;
	logic          ext_clk;
	logic [3:0]    trace_level = 4'h0;
	logic          trace_hold = 1'b0;
	logic          trace_ready;
	logic          clk_on = 1'b0;
	logic [SW-1:0] pattern = P0;
	logic [31:0]   rv;
	int            errors = 0;
	int            checks = 0;
	always #5 hclk = ~hclk;
	arcc_top u_arcc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .irq,
		.probe_data, .ext_clk, .trace_level, .trace_hold, .trace_ready);
	arcc_target u_arcc_target (.pattern, .clk_on, .ext_clk, .probe_data);
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out;
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do
			@(posedge hclk);
		while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do
			@(posedge hclk);
		while (hready !== 1'b1);
		rv = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string n);
		xfer(a, 1'b0, 32'h0);
		chk(n, rv, e);
	endtask
	task automatic idle(input int n);
		repeat (3) @(posedge hclk);
		for (int i = 0; i < n && trace_ready !== 1'b1; i++)
			@(posedge hclk);
		chk("ready", {31'h0, trace_ready}, 32'h1);
	endtask
	task automatic rec(input logic [31:0] c, input int n);
		xfer(OFS_CTRL, 1'b1, c);
		idle(n);
	endtask
	initial
	begin
		#500000;
		errors++;
		close_out();
	end
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (ROWS[i])
		begin
			if (ROWS[i].w)
				xfer(ROWS[i].a, 1'b1, ROWS[i].d);
			rdc(ROWS[i].a, ROWS[i].e, "row");
		end
		rec(32'h100, 2000);
		repeat (700) @(posedge hclk);
		rdc(OFS_COUNT, 32'h1, "manual");
		rdc(OFS_STATUS, 32'h0, "status");
		rdc(OFS_ACQ_LO, 32'h1234FF0F, "acq lo");
		rdc(OFS_ACQ_HI, 32'h0000ABCD, "acq hi");
		for (int m = 2; m < 6; m++)
		begin
			pattern <= P0;
			rec(32'h100, 2000);
			xfer(OFS_CTRL, 1'b1, 32'h400);
			repeat (600) @(posedge hclk);
			rdc(OFS_REF_LO, 32'h1234FF0F, "copy");
			pattern <= m[0] ? P1 : P0;
			rec(32'h100 | 32'(m), 3000);
			rdc(OFS_COUNT, 32'h1, "cmp stop");
			rdc(OFS_REF_LO, 32'h1234FF0F, "ref kept");
			rv = m[0] ? 32'hAAAAF0F0 : 32'h1234FF0F;
			rdc(OFS_ACQ_LO, rv, "acq");
		end
		pattern <= P0;
		xfer(OFS_INT_ST, 1'b0, 32'h0);
		xfer(OFS_INT_MSK, 1'b1, 32'h3);
		xfer(OFS_LIMIT, 1'b1, 32'h3);
		rec(32'h101, 4000);
		rdc(OFS_COUNT, 32'h3, "limit");
		chk("irq", {31'h0, irq}, 32'h1);
		rdc(OFS_INT_ST, 32'h3, "int");
		rdc(OFS_INT_ST, 32'h0, "int clr");
		@(posedge hclk);
		chk("irq clr", {31'h0, irq}, 32'h0);
		xfer(OFS_CTRL, 1'b1, 32'h101);
		repeat (100) @(posedge hclk);
		trace_level <= 4'h5;
		trace_hold <= 1'b1;
		repeat (10) @(posedge hclk);
		rdc(OFS_STATUS, 32'h00010506, "stuck");
		repeat (600) @(posedge hclk);
		rdc(OFS_COUNT, 32'h0, "frozen");
		trace_hold <= 1'b0;
		trace_level <= 4'h0;
		idle(4000);
		rdc(OFS_COUNT, 32'h3, "resume");
		xfer(OFS_LIMIT, 1'b1, 32'h0);
		xfer(OFS_CTRL, 1'b1, 32'h103);
		repeat (1200) @(posedge hclk);
		xfer(OFS_CTRL, 1'b1, 32'h203);
		idle(10);
		rdc(OFS_COUNT, 32'h2, "halt");
		xfer(OFS_LIMIT, 1'b1, 32'h1);
		clk_on <= 1'b1;
		xfer(OFS_CTRL, 1'b1, 32'h109);
		repeat (2000) @(posedge hclk);
		clk_on <= 1'b0;
		repeat (300) @(posedge hclk);
		rdc(OFS_STATUS, 32'h0001000B, "no clock");
		clk_on <= 1'b1;
		idle(12000);
		rdc(OFS_COUNT, 32'h1, "clock back");
		clk_on <= 1'b0;
		xfer(OFS_CTRL, 1'b1, 32'h101);
		repeat (50) @(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(OFS_LIMIT, 32'h0, "rst limit");
		close_out();
	end
endmodule // tb_top
